// ---- logic/ccbr_top.sv ----
// Buffer registers for the A and B compare/capture registers of channels 3 and 4,
// together with those four general registers and their match/capture logic.
// Assumes counters, edge selection and pin control live elsewhere on the same clock;
// capture strobes arrive already synchronised and edge-qualified.
`timescale 1ns/10ps
module ccbr_top #(
  parameter int WIDTH = 16
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   standby,
  input  wire ccbr_pkg::ccbr_bus_req_t buf_bus,
  input  wire ccbr_pkg::ccbr_bus_req_t gr_bus,
  input  wire ccbr_pkg::ccbr_ctrl_t   ctrl,
  input  wire logic [WIDTH-1:0]       ch3_counter,
  input  wire logic [WIDTH-1:0]       ch4_counter,
  output logic      [WIDTH-1:0]       buf_rdata,
  output logic                        buf_ack,
  output logic      [WIDTH-1:0]       gr_rdata,
  output logic                        gr_ack,
  output logic      [3:0]             compare_match,
  output logic      [3:0]             capture_done,
  output logic      [3:0]             match_flag_set
);
  localparam int N = ccbr_pkg::CCBR_NUM_REGS;

  logic [WIDTH-1:0]   compare_capture [N];
  logic [N*WIDTH-1:0] buf_all;
  logic [N*WIDTH-1:0] next_buf;
  logic [N-1:0]       buf_load;
  logic [N-1:0]       match_now;
  logic [WIDTH-1:0]   gr_rd_word;
  logic [WIDTH-1:0]   mem_rd;

  // Merges a byte-lane write into an existing word.
  function automatic logic [15:0] ccbr_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  be);
    ccbr_merge = old_v;
    if (be[1]) ccbr_merge[15:8] = new_v[15:8]; // see [R6]
    if (be[0]) ccbr_merge[7:0]  = new_v[7:0];  // see [R6]
  endfunction : ccbr_merge

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      logic [WIDTH-1:0] counter;
      logic             buf_wr;
      logic             gr_wr;
      assign counter = (g < 2) ? ch3_counter : ch4_counter; // see [R1]
      assign buf_wr  = buf_bus.req && buf_bus.wr && (buf_bus.idx == 2'(g)); // see [R6]
      assign gr_wr   = gr_bus.req && gr_bus.wr && (gr_bus.idx == 2'(g));
      assign match_now[g] = !ctrl.capture_mode[g] && (compare_capture[g] == counter); // see [R8]

      // Hardware transfer has priority over a CPU write in the same clock, so
      // a captured value is never overwritten by a late software access.
      always_comb begin
        buf_load[g] = 1'b0;
        next_buf[g*WIDTH +: WIDTH] = buf_all[g*WIDTH +: WIDTH];
        if (ctrl.buffer_enable[g] && ctrl.capture_mode[g] && ctrl.capture_evt[g]) begin
          buf_load[g] = 1'b1;
          next_buf[g*WIDTH +: WIDTH] = compare_capture[g]; // see [R3] see [R5] see [R10]
        end else if (buf_wr) begin
          buf_load[g] = 1'b1;
          next_buf[g*WIDTH +: WIDTH] =
            ccbr_merge(buf_all[g*WIDTH +: WIDTH], buf_bus.wdata, buf_bus.byte_en);
        end
      end

      always_ff @(posedge clk) begin
        if (!rst_n || standby) begin
          compare_capture[g] <= ccbr_pkg::CCBR_RESET_VAL;
        end else if (ctrl.capture_mode[g] && ctrl.capture_evt[g]) begin
          compare_capture[g] <= counter; // see [R9] see [R10]
        end else if (!ctrl.capture_mode[g] && match_now[g] && ctrl.buffer_enable[g]) begin
          compare_capture[g] <= buf_all[g*WIDTH +: WIDTH]; // see [R2] see [R4] see [R5]
        end else if (gr_wr) begin
          compare_capture[g] <= ccbr_merge(compare_capture[g], gr_bus.wdata, gr_bus.byte_en);
        end
      end

      always_ff @(posedge clk) begin
        if (!rst_n || standby) begin
          compare_match[g]  <= 1'b0;
          capture_done[g]   <= 1'b0;
          match_flag_set[g] <= 1'b0;
        end else begin
          compare_match[g]  <= match_now[g]; // see [R8]
          capture_done[g]   <= ctrl.capture_mode[g] && ctrl.capture_evt[g]; // see [R9]
          match_flag_set[g] <= match_now[g] || (ctrl.capture_mode[g] && ctrl.capture_evt[g]);
        end
      end
    end
  endgenerate

  ccbr_buffer_mem #(
    .WIDTH (WIDTH),
    .DEPTH (N)
  ) u_mem (
    .clk       (clk),
    .rst_n     (rst_n),
    .init      (standby),
    .load      (buf_load),
    .load_data (next_buf),
    .rd_idx    (buf_bus.idx),
    .rd_data   (mem_rd),
    .all_data  (buf_all)
  );

  assign gr_rd_word = compare_capture[gr_bus.idx];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      buf_ack   <= 1'b0;
      buf_rdata <= ccbr_pkg::CCBR_RESET_VAL;
    end else begin
      buf_ack   <= buf_bus.req;
      buf_rdata <= mem_rd;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gr_ack   <= 1'b0;
      gr_rdata <= ccbr_pkg::CCBR_RESET_VAL;
    end else begin
      gr_ack   <= gr_bus.req;
      gr_rdata <= gr_rd_word; // see [R6]
    end
  end
endmodule : ccbr_top

// ---- logic/ccbr_pkg.sv ----
// Package for the channel 3/4 compare/capture buffer registers.
// Assumes a 16-bit internal CPU bus with byte strobes and one system clock.
// Operation
// [R1] Four 16-bit buffers, channels 3 and 4.
// [R2] Compare match loads buffer into general register.
// [R3] Capture moves general register into buffer.
// [R4] Four independent buffer enable bits.
// [R5] Buffer role follows its general register mode.
// [R6] Word or byte access to each buffer.
// [R7] Buffers reset to all ones, also standby.
// [R8] Compare register matched continuously against counter.
// [R9] Capture loads counter, sets flag together.
// [R10] Buffered capture shifts old value same clock.
package ccbr_pkg;
  localparam int          CCBR_DATA_W    = 16;
  localparam int          CCBR_NUM_REGS  = 4;
  localparam int          CCBR_ADDR_W    = 2;
  // Register index on the local select bus.
  localparam logic [1:0]  CCBR_IDX_CH3_A = 2'h0;
  localparam logic [1:0]  CCBR_IDX_CH3_B = 2'h1;
  localparam logic [1:0]  CCBR_IDX_CH4_A = 2'h2;
  localparam logic [1:0]  CCBR_IDX_CH4_B = 2'h3;
  // Field positions of the enables inside the function control vector.
  localparam int          CCBR_EN_CH3_A  = 0;
  localparam int          CCBR_EN_CH3_B  = 1;
  localparam int          CCBR_EN_CH4_A  = 2;
  localparam int          CCBR_EN_CH4_B  = 3;
  localparam logic [15:0] CCBR_RESET_VAL = 16'hFFFF;

  typedef struct packed {
    logic             req;
    logic             wr;
    logic [1:0]       idx;
    logic [1:0]       byte_en;
    logic [15:0]      wdata;
  } ccbr_bus_req_t;

  typedef struct packed {
    logic [3:0]       capture_mode;
    logic [3:0]       capture_evt;
    logic [3:0]       buffer_enable;
  } ccbr_ctrl_t;
endpackage : ccbr_pkg

// ---- logic/ccbr_buffer_mem.sv ----
// Four-word buffer store with whole-word loads and a registered read port.
// Assumes one system clock; hardware loads and CPU writes arrive already merged.
`timescale 1ns/10ps
module ccbr_buffer_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       init,
  input  wire logic [DEPTH-1:0]           load,
  input  wire logic [DEPTH*WIDTH-1:0]     load_data,
  input  wire logic [$clog2(DEPTH)-1:0]   rd_idx,
  output logic      [WIDTH-1:0]           rd_data,
  output logic      [DEPTH*WIDTH-1:0]     all_data
);
  logic [WIDTH-1:0] word [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_word
      always_ff @(posedge clk) begin
        if (!rst_n || init) begin
          word[g] <= ccbr_pkg::CCBR_RESET_VAL; // see [R7]
        end else if (load[g]) begin
          word[g] <= load_data[g*WIDTH +: WIDTH];
        end
      end
      assign all_data[g*WIDTH +: WIDTH] = word[g];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= ccbr_pkg::CCBR_RESET_VAL;
    end else begin
      rd_data <= word[rd_idx];
    end
  end
endmodule : ccbr_buffer_mem

// ---- test/ccbr_monitor.sv ----
// Checker for the channel 3/4 buffer block, bound to ccbr_top.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/10ps
module ccbr_monitor #(
  parameter int WIDTH = 16
) (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    standby,
  input wire ccbr_pkg::ccbr_bus_req_t buf_bus,
  input wire ccbr_pkg::ccbr_bus_req_t gr_bus,
  input wire ccbr_pkg::ccbr_ctrl_t    ctrl,
  input wire logic [WIDTH-1:0]        buf_rdata,
  input wire logic                    buf_ack,
  input wire logic                    gr_ack,
  input wire logic [3:0]              compare_match,
  input wire logic [3:0]              capture_done,
  input wire logic [3:0]              match_flag_set
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  buf_ack_a: assert property (buf_bus.req |=> buf_ack)
    else $error("buffer access not acknowledged");
  buf_idle_a: assert property (!buf_bus.req |=> !buf_ack)
    else $error("buffer ack without access");
  gr_ack_a: assert property (gr_bus.req |=> gr_ack)
    else $error("register access not acknowledged");
  gr_idle_a: assert property (!gr_bus.req |=> !gr_ack)
    else $error("register ack without access");
  capture_pulse_a: assert property (1'b1 |=> capture_done ==
    $past(ctrl.capture_evt & ctrl.capture_mode)) else $error("capture pulse wrong");
  capture_flag_a: assert property ((capture_done & ~match_flag_set) == 4'h0)
    else $error("capture without flag");
  mode_match_a: assert property (1'b1 |=>
    (compare_match & $past(ctrl.capture_mode)) == 4'h0) else $error("match in capture mode");
  standby_init_a: assert property ($fell(standby) ##1 (buf_bus.req && !buf_bus.wr)
    |=> ##1 buf_rdata == 16'hFFFF) else $error("buffer not reinitialised");
endmodule : ccbr_monitor
bind ccbr_top ccbr_monitor #(.WIDTH(WIDTH)) u_mon (.clk(clk), .rst_n(rst_n),
  .standby(standby), .buf_bus(buf_bus), .gr_bus(gr_bus), .ctrl(ctrl),
  .buf_rdata(buf_rdata), .buf_ack(buf_ack), .gr_ack(gr_ack), .compare_match(compare_match),
  .capture_done(capture_done), .match_flag_set(match_flag_set));

// ---- test/ccbr_cpu_model.sv ----
// CPU side of one internal 16-bit bus, word or byte accesses.
// Assumes ack one cycle after a taken request; data is read one edge after the ack.
`timescale 1ns/10ps
module ccbr_cpu_model (
  input  wire logic              clk,
  input  wire logic              ack,
  input  wire logic [15:0]       rdata,
  output ccbr_pkg::ccbr_bus_req_t bus
);
  initial bus = '0;
  // Repeated taking of a held request is harmless: reads and writes are idempotent.
  task automatic access(input logic wr, input logic [1:0] idx, input logic [1:0] be,
                        input logic [15:0] wd, output logic [15:0] rd);
    int n = 0;
    @(posedge clk);
    bus <= '{1'b1, wr, idx, be, wd};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 8);
    bus.req   <= 1'b0;
    bus.wdata <= ~wd;
    @(posedge clk);
    rd = rdata;
  endtask : access
endmodule : ccbr_cpu_model

// ---- test/testbench.sv ----
// Self-checking bench for ccbr_top with two CPU bus models.
// Assumes the monitor is bound in; counters are driven directly.
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic standby = 1'b0;
  ccbr_pkg::ccbr_ctrl_t    ctrl = '0;
  ccbr_pkg::ccbr_bus_req_t buf_bus, gr_bus;
  logic [15:0] c3 = 16'h0000, c4 = 16'h0000, buf_rdata, gr_rdata;
  logic        buf_ack, gr_ack;
  int          mismatches = 0, n_compared = 0;
  always #12.5 clk = ~clk;
  ccbr_top u_dut (.clk(clk), .rst_n(rst_n), .standby(standby), .buf_bus(buf_bus),
    .gr_bus(gr_bus), .ctrl(ctrl), .ch3_counter(c3), .ch4_counter(c4), .buf_rdata(buf_rdata),
    .buf_ack(buf_ack), .gr_rdata(gr_rdata), .gr_ack(gr_ack), .compare_match(),
    .capture_done(), .match_flag_set());
  ccbr_cpu_model u_buf (.clk(clk), .ack(buf_ack), .rdata(buf_rdata), .bus(buf_bus));
  ccbr_cpu_model u_gr (.clk(clk), .ack(gr_ack), .rdata(gr_rdata), .bus(gr_bus));
  task automatic put(input bit g, input logic [1:0] i, be, input logic [15:0] d);
    logic [15:0] r;
    if (g) u_gr.access(1'b1, i, be, d, r);
    else u_buf.access(1'b1, i, be, d, r);
  endtask : put
  task automatic get(input bit g, input logic [1:0] i, input logic [15:0] e);
    logic [15:0] r;
    if (g) u_gr.access(1'b0, i, 2'h3, 16'h0000, r);
    else u_buf.access(1'b0, i, 2'h3, 16'h0000, r);
    n_compared++;
    if (r !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, r, e);
    end
  endtask : get
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      get(0, i[1:0], 16'hFFFF);
      get(1, i[1:0], 16'hFFFF);
    end
  endtask : t_reset
  task automatic t_bytes();
    put(0, 2'h3, 2'h3, 16'h1234);
    put(0, 2'h3, 2'h2, 16'hAB00);
    get(0, 2'h3, 16'hAB34);
    put(0, 2'h3, 2'h1, 16'h00CD);
    get(0, 2'h3, 16'hABCD);
  endtask : t_bytes
  task automatic t_compare();
    ctrl.buffer_enable <= 4'h1;
    put(1, 2'h0, 2'h3, 16'h0010);
    put(1, 2'h1, 2'h3, 16'h0010);
    put(0, 2'h0, 2'h3, 16'h0020);
    put(0, 2'h1, 2'h3, 16'h0040);
    @(posedge clk) c3 <= 16'h0010;
    @(posedge clk) c3 <= 16'h0000;
    get(1, 2'h0, 16'h0020);
    get(1, 2'h1, 16'h0010);
  endtask : t_compare
  task automatic t_capture();
    ctrl.buffer_enable <= 4'h4;
    ctrl.capture_mode  <= 4'h4;
    put(1, 2'h2, 2'h3, 16'h0055);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) begin
        c4 <= k ? 16'h0888 : 16'h0777;
        ctrl.capture_evt <= 4'h4;
      end
      @(posedge clk) ctrl.capture_evt <= 4'h0;
    end
    get(1, 2'h2, 16'h0888);
    get(0, 2'h2, 16'h0777);
  endtask : t_capture
  task automatic t_standby();
    standby <= 1'b1;
    repeat (2) @(posedge clk);
    standby <= 1'b0;
    get(0, 2'h0, 16'hFFFF);
  endtask : t_standby
  task automatic stop_test();
    $display("mismatches %0d n_compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_bytes();
    t_compare();
    t_capture();
    t_standby();
    stop_test();
  end
endmodule : testbench
